// >>> rtl/hmp_pkg.sv
/*
  Shared constants of the host mailbox port: register addresses, control
  field layout, pin reset levels, strobe timing and the host's own registers.
  Assumes a 10 MHz aclk at both ends.
*/
package hmp_pkg;

  // Register addresses on the two address lines
  localparam logic [1:0] ADDR_MAILBOX   = 2'h0;
  localparam logic [1:0] ADDR_CONTROL   = 2'h1;
  localparam logic [1:0] ADDR_AUDIO_ONE = 2'h2;
  localparam logic [1:0] ADDR_AUDIO_TWO = 2'h3;

  // Control/status field layout
  localparam int         CTRL_READY_BIT = 1;
  localparam int         CTRL_BUSY_BIT  = 2;
  localparam int         CTRL_SEL_LSB   = 3;
  localparam logic [1:0] CTRL_SEL_VALUE = 2'h3;
  localparam logic [7:0] CTRL_WRITE_VAL = 8'h18;
  localparam logic [7:0] AUDIO_READ_VAL = 8'h00;

  // Bus style strap: separate strobes, or data strobe plus read/write select
  localparam logic STYLE_SEPARATE = 1'b0;
  localparam logic STYLE_STROBE   = 1'b1;

  // Pin vector idle levels: {style, cs_n, wr_ds_n, rd_rw, addr[1:0], data[7:0]}
  localparam logic [13:0] DEV_PIN_IDLE  = 14'h1C00;
  // Host side: {busy, irq_n, data[7:0]}
  localparam logic [9:0]  HOST_PIN_IDLE = 10'h100;

  // Each strobe phase; covers two-flop sync at both ends plus a register stage
  localparam int         CLK_MHZ    = 10;
  localparam int         STROBE_NS  = 800;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS * CLK_MHZ + 999) / 1000);

  // Host command codes in the command register
  localparam logic [1:0] OP_WRITE_BYTE = 2'h0;
  localparam logic [1:0] OP_READ_BYTE  = 2'h1;
  localparam logic [1:0] OP_WRITE_WORD = 2'h2;
  localparam logic [1:0] OP_READ_WORD  = 2'h3;

  // Host registers on AXI4-Lite
  localparam logic [4:0] OFF_COMMAND = 5'h00;
  localparam logic [4:0] OFF_WDATA   = 5'h04;
  localparam logic [4:0] OFF_RDATA   = 5'h08;
  localparam logic [4:0] OFF_STATUS  = 5'h0C;
  localparam logic [4:0] OFF_CONFIG  = 5'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> rtl/hmp_bus_if.sv
/*
  Eight-bit parallel host bus between the host controller and the device.
  Assumes the bench ties the style strap of both ends to the same level;
  the shared data line is resolved here from the two output enables.
*/
`timescale 1ns/1ps
interface hmp_bus_if;
  logic       cs_n;
  logic       wr_ds_n;
  logic       rd_rw;
  logic [1:0] addr;
  logic [7:0] host_data;
  logic       host_oe;
  logic [7:0] dev_data;
  logic       dev_oe;
  logic [7:0] data_line;
  logic       busy;
  logic       irq_n;

  // Undriven line floats high, as with pull-up resistors
  assign data_line = dev_oe ? dev_data : (host_oe ? host_data : 8'hFF);

  modport device (
    input  cs_n,
    input  wr_ds_n,
    input  rd_rw,
    input  addr,
    input  data_line,
    output dev_data,
    output dev_oe,
    output busy,
    output irq_n
  );

  modport host (
    output cs_n,
    output wr_ds_n,
    output rd_rw,
    output addr,
    output host_data,
    output host_oe,
    input  data_line,
    input  busy,
    input  irq_n
  );
endinterface

// >>> rtl/hmp_device.sv
/*
  Device end of the parallel host port: mailbox, control/status and two
  audio input registers behind an 8-bit bus, plus the processor side.
  Assumes host pins are asynchronous to aclk and that the host holds address
  and data stable across each strobe.
*/
`timescale 1ns/1ps
module hmp_device (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        bus_style,
  hmp_bus_if.device        bus,
  output logic [31:0]      in_word,
  output logic             input_busy_flag,
  input  wire logic        proc_take,
  input  wire logic [31:0] out_word,
  input  wire logic        out_load,
  output logic             output_ready_flag,
  output logic [7:0]       audio_one_data,
  output logic             audio_one_valid,
  output logic [7:0]       audio_two_data,
  output logic             audio_two_valid
);

  localparam int SW = 14;

  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic          style;
  logic          cs_n;
  logic          wr_ds_n;
  logic          rd_rw;
  logic [1:0]    addr;
  logic [7:0]    data;
  logic          write_act;
  logic          read_act;
  logic          wr_prev;
  logic          rd_prev;
  logic          write_end;
  logic          read_start;
  logic          read_end;
  logic [1:0]    wr_cnt;
  logic [1:0]    rd_cnt;
  logic [23:0]   asm_word;
  logic [31:0]   mailbox_out;
  logic [1:0]    byte_sel;
  logic          word_done;
  logic          word_read_done;
  logic          next_busy;
  logic          next_ready;
  logic          busy;
  logic          ready;
  logic          irq_n;
  logic [7:0]    dev_data;
  logic          dev_oe;
  logic [7:0]    read_value;

  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] idx);
    case (idx)
      2'h0:    pick_byte = w[31:24];
      2'h1:    pick_byte = w[23:16];
      2'h2:    pick_byte = w[15:8];
      default: pick_byte = w[7:0];
    endcase
  endfunction

  assign pin_raw = {bus_style, bus.cs_n, bus.wr_ds_n, bus.rd_rw, bus.addr, bus.data_line};

  // Every pin passes two flops; idle levels keep strobes inactive at release
  for (genvar i = 0; i < SW; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_meta[i] <= hmp_pkg::DEV_PIN_IDLE[i];
        pin_sync[i] <= hmp_pkg::DEV_PIN_IDLE[i];
      end else begin
        pin_meta[i] <= pin_raw[i];
        pin_sync[i] <= pin_meta[i];
      end
    end
  end

  assign style   = pin_sync[13];
  assign cs_n    = pin_sync[12];
  assign wr_ds_n = pin_sync[11];
  assign rd_rw   = pin_sync[10];
  assign addr    = pin_sync[9:8];
  assign data    = pin_sync[7:0];

  always_comb begin
    if (style == hmp_pkg::STYLE_STROBE) begin
      write_act = !cs_n && !wr_ds_n && !rd_rw;
      read_act  = !cs_n && !wr_ds_n && rd_rw;
    end else begin
      write_act = !cs_n && !wr_ds_n;
      read_act  = !cs_n && !rd_rw;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
    end else begin
      wr_prev <= write_act;
      rd_prev <= read_act;
    end
  end

  // Byte taken as the strobe returns high
  assign write_end      = wr_prev && !write_act;
  assign read_start     = !rd_prev && read_act;
  assign read_end       = rd_prev && !read_act;
  assign word_done      = write_end && addr == hmp_pkg::ADDR_MAILBOX && wr_cnt == 2'h3;
  assign word_read_done = read_end && addr == hmp_pkg::ADDR_MAILBOX && rd_cnt == 2'h3;

  // Host write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_cnt          <= 2'h0;
      asm_word        <= 24'h000000;
      in_word         <= 32'h00000000;
      byte_sel        <= hmp_pkg::CTRL_SEL_VALUE;
      audio_one_data  <= 8'h00;
      audio_one_valid <= 1'b0;
      audio_two_data  <= 8'h00;
      audio_two_valid <= 1'b0;
    end else begin
      audio_one_valid <= 1'b0;
      audio_two_valid <= 1'b0;
      if (write_end) begin
        case (addr)
          hmp_pkg::ADDR_MAILBOX: begin
            asm_word <= {asm_word[15:0], data};
            wr_cnt   <= wr_cnt + 2'h1;
            if (wr_cnt == 2'h3) begin
              in_word <= {asm_word, data};
            end
          end
          hmp_pkg::ADDR_CONTROL: begin
            // Flag bits of the written byte are dropped
            byte_sel <= data[hmp_pkg::CTRL_SEL_LSB +: 2];
            wr_cnt   <= 2'h0;
          end
          hmp_pkg::ADDR_AUDIO_ONE: begin
            audio_one_data  <= data;
            audio_one_valid <= 1'b1;
            wr_cnt          <= 2'h0;
          end
          default: begin
            audio_two_data  <= data;
            audio_two_valid <= 1'b1;
            wr_cnt          <= 2'h0;
          end
        endcase
      end
    end
  end

  // Host completing a word wins over a take in the same cycle
  always_comb begin
    next_busy = busy;
    if (word_done) begin
      next_busy = 1'b1;
    end else if (proc_take) begin
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy            <= 1'b0;
      input_busy_flag <= 1'b0;
    end else begin
      busy            <= next_busy;
      input_busy_flag <= next_busy;
    end
  end

  assign bus.busy = busy;

  // A new post wins over the host finishing its read
  always_comb begin
    next_ready = ready;
    if (out_load) begin
      next_ready = 1'b1;
    end else if (word_read_done) begin
      next_ready = 1'b0;
    end
  end

  // Posting mid-read swaps the word under the host; the processor side avoids it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready             <= 1'b0;
      output_ready_flag <= 1'b0;
      irq_n             <= 1'b1;
      mailbox_out       <= 32'h00000000;
    end else begin
      ready             <= next_ready;
      output_ready_flag <= next_ready;
      irq_n             <= !next_ready;
      if (out_load) begin
        mailbox_out <= out_word;
      end
    end
  end

  assign bus.irq_n = irq_n;

  always_comb begin
    case (addr)
      hmp_pkg::ADDR_MAILBOX: read_value = pick_byte(mailbox_out, rd_cnt);
      hmp_pkg::ADDR_CONTROL: begin
        read_value = 8'h00;
        read_value[hmp_pkg::CTRL_SEL_LSB +: 2] = byte_sel;
        read_value[hmp_pkg::CTRL_BUSY_BIT]     = busy;
        read_value[hmp_pkg::CTRL_READY_BIT]    = ready;
      end
      default: read_value = hmp_pkg::AUDIO_READ_VAL;
    endcase
  end

  // Host read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_data <= 8'h00;
      dev_oe   <= 1'b0;
      rd_cnt   <= 2'h0;
    end else begin
      if (read_start) begin
        dev_data <= read_value;
        dev_oe   <= 1'b1;
      end else if (read_end) begin
        dev_oe <= 1'b0;
        if (addr == hmp_pkg::ADDR_MAILBOX) begin
          rd_cnt <= rd_cnt + 2'h1;
        end else begin
          rd_cnt <= 2'h0;
        end
      end
    end
  end

  assign bus.dev_data = dev_data;
  assign bus.dev_oe   = dev_oe;

endmodule // hmp_device

// >>> rtl/hmp_host.sv
/*
  Host controller end of the parallel host port. Software issues byte and
  word commands through AXI4-Lite registers; the engine runs the strobes.
  Assumes device pins are asynchronous and the device strap matches CONFIG.
*/
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module hmp_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             bus_style,
  hmp_bus_if.host          bus
);

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_GAP} hmp_state_e;

  hmp_state_e  state;
  logic [4:0]  aw_addr;
  logic [31:0] w_data;
  logic        wr_fire;
  logic        launch;
  logic        bad_cmd;
  logic [31:0] wdata_reg;
  logic [3:0]  cmd_reg;
  logic        refused;
  logic [31:0] rd_word;
  logic [31:0] first_word;
  logic [31:0] shift;
  logic [1:0]  left;
  logic        is_read;
  logic [3:0]  cnt;
  logic        phase_end;
  logic [9:0]  pin_meta;
  logic [9:0]  pin_sync;
  logic        busy_s;
  logic        irq_n_s;
  logic [7:0]  data_s;
  logic [31:0] read_mux;
  logic        read_hit;
  logic        cs_n;
  logic        wr_ds_n;
  logic        rd_rw;
  logic [1:0]  addr;
  logic [7:0]  host_data;
  logic        host_oe;

  for (genvar i = 0; i < 10; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_meta[i] <= hmp_pkg::HOST_PIN_IDLE[i];
        pin_sync[i] <= hmp_pkg::HOST_PIN_IDLE[i];
      end else begin
        pin_meta[i] <= i == 9 ? bus.busy : (i == 8 ? bus.irq_n : bus.data_line[i % 8]);
        pin_sync[i] <= pin_meta[i];
      end
    end
  end

  assign busy_s  = pin_sync[9];
  assign irq_n_s = pin_sync[8];
  assign data_s  = pin_sync[7:0];

  // AXI4-Lite write: address and data in either order, response after both
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= hmp_pkg::RESP_OKAY;
      aw_addr       <= 5'h00;
      w_data        <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          hmp_pkg::OFF_COMMAND: s_axi_bresp <= state == H_IDLE ? hmp_pkg::RESP_OKAY : hmp_pkg::RESP_SLVERR;
          hmp_pkg::OFF_WDATA, hmp_pkg::OFF_CONFIG: s_axi_bresp <= hmp_pkg::RESP_OKAY;
          default: s_axi_bresp <= hmp_pkg::RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Write strobes ignored: WDATA takes the whole word, COMMAND bits 3:0, CONFIG bit 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_reg <= 32'h00000000;
      cmd_reg   <= 4'h0;
      bus_style <= hmp_pkg::STYLE_SEPARATE;
    end else if (wr_fire) begin
      if (aw_addr == hmp_pkg::OFF_WDATA) begin
        wdata_reg <= w_data;
      end
      if (launch) begin
        cmd_reg <= w_data[3:0];
      end
      if (aw_addr == hmp_pkg::OFF_CONFIG && state == H_IDLE) begin
        bus_style <= w_data[0];
      end
    end
  end

  assign launch = wr_fire && aw_addr == hmp_pkg::OFF_COMMAND && state == H_IDLE;

  always_comb begin
    bad_cmd = 1'b0;
    case (w_data[1:0])
      hmp_pkg::OP_WRITE_BYTE: bad_cmd = w_data[3:2] == hmp_pkg::ADDR_MAILBOX;
      hmp_pkg::OP_READ_BYTE:  bad_cmd = w_data[3:2] != hmp_pkg::ADDR_CONTROL;
      hmp_pkg::OP_WRITE_WORD: bad_cmd = w_data[3:2] != hmp_pkg::ADDR_MAILBOX || busy_s;
      default:                bad_cmd = w_data[3:2] != hmp_pkg::ADDR_MAILBOX || irq_n_s;
    endcase
    if (w_data[1] == 1'b1) begin
      first_word = wdata_reg;
    end else if (w_data[3:2] == hmp_pkg::ADDR_CONTROL) begin
      first_word = {hmp_pkg::CTRL_WRITE_VAL, 24'h000000};
    end else begin
      first_word = {wdata_reg[7:0], 24'h000000};
    end
  end

  assign phase_end = cnt == 4'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= hmp_pkg::STROBE_CYC;
    end else if (state == H_IDLE || phase_end) begin
      cnt <= hmp_pkg::STROBE_CYC;
    end else begin
      cnt <= cnt - 4'h1;
    end
  end

  // Strobe engine; chip select stays low across all bytes of a word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= H_IDLE;
      cs_n      <= 1'b1;
      wr_ds_n   <= 1'b1;
      rd_rw     <= 1'b1;
      addr      <= hmp_pkg::ADDR_MAILBOX;
      host_data <= 8'h00;
      host_oe   <= 1'b0;
      shift     <= 32'h00000000;
      left      <= 2'h0;
      is_read   <= 1'b0;
      rd_word   <= 32'h00000000;
      refused   <= 1'b0;
    end else begin
      case (state)
        H_IDLE: begin
          if (launch) begin
            refused <= bad_cmd;
            if (!bad_cmd) begin
              state     <= H_SETUP;
              cs_n      <= 1'b0;
              addr      <= w_data[3:2];
              is_read   <= w_data[0];
              rd_rw     <= bus_style == hmp_pkg::STYLE_STROBE ? w_data[0] : 1'b1;
              host_oe   <= !w_data[0];
              shift     <= first_word;
              host_data <= first_word[31:24];
              left      <= w_data[1] ? 2'h3 : 2'h0;
              rd_word   <= 32'h00000000;
            end
          end
        end
        H_SETUP: begin
          if (phase_end) begin
            state <= H_STROBE;
            if (bus_style == hmp_pkg::STYLE_SEPARATE && is_read) begin
              rd_rw <= 1'b0;
            end else begin
              wr_ds_n <= 1'b0;
            end
          end
        end
        H_STROBE: begin
          if (phase_end) begin
            state   <= H_HOLD;
            wr_ds_n <= 1'b1;
            if (bus_style == hmp_pkg::STYLE_SEPARATE) begin
              rd_rw <= 1'b1;
            end
            if (is_read) begin
              rd_word <= {rd_word[23:0], data_s};
            end
          end
        end
        H_HOLD: begin
          if (phase_end) begin
            if (left == 2'h0) begin
              state   <= H_GAP;
              cs_n    <= 1'b1;
              host_oe <= 1'b0;
              rd_rw   <= 1'b1;
            end else begin
              state     <= H_SETUP;
              left      <= left - 2'h1;
              shift     <= {shift[23:0], 8'h00};
              host_data <= shift[23:16];
            end
          end
        end
        H_GAP: begin
          if (phase_end) begin
            state <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  assign bus.cs_n      = cs_n;
  assign bus.wr_ds_n   = wr_ds_n;
  assign bus.rd_rw     = rd_rw;
  assign bus.addr      = addr;
  assign bus.host_data = host_data;
  assign bus.host_oe   = host_oe;

  always_comb begin
    read_hit = 1'b1;
    case (s_axi_araddr)
      hmp_pkg::OFF_COMMAND: read_mux = {28'h0000000, cmd_reg};
      hmp_pkg::OFF_WDATA:   read_mux = wdata_reg;
      hmp_pkg::OFF_RDATA:   read_mux = rd_word;
      hmp_pkg::OFF_STATUS:  read_mux = {27'h0000000, bus_style, !irq_n_s, busy_s, refused, state != H_IDLE};
      hmp_pkg::OFF_CONFIG:  read_mux = {31'h00000000, bus_style};
      default: begin
        read_mux = 32'h00000000;
        read_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= hmp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= read_mux;
      s_axi_rresp   <= read_hit ? hmp_pkg::RESP_OKAY : hmp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // hmp_host

// >>> test/hmp_bus_asserts.sv
/* Checker on the parallel host bus wires.
   Assumes it watches the one interface that joins both ends. */
`timescale 1ns/1ps
module hmp_bus_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       cs_n,
  input wire logic       wr_ds_n,
  input wire logic       rd_rw,
  input wire logic [1:0] addr,
  input wire logic [7:0] host_data,
  input wire logic       host_oe,
  input wire logic       dev_oe,
  input wire logic       busy,
  input wire logic       irq_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_ONE_DRIVER: assert property (!(dev_oe && host_oe))
    else $error("both ends drive data");
  AST_RESET_IDLE: assert property ($rose(aresetn) |-> !busy && irq_n)
    else $error("pins not idle after reset");
  AST_CS_STROBE: assert property (!wr_ds_n |-> !cs_n)
    else $error("strobe without chip select");
  AST_ADDR_HELD: assert property (!cs_n && $past(!cs_n) |-> $stable(addr))
    else $error("address moved in a cycle");
  AST_DATA_HELD: assert property (host_oe && !wr_ds_n && $past(!wr_ds_n) |-> $stable(host_data))
    else $error("write data moved under strobe");
  AST_STROBE_LEN: assert property ($fell(wr_ds_n) |-> !wr_ds_n [*8] ##1 wr_ds_n)
    else $error("strobe phase not eight cycles");
  AST_DEV_IN_CYCLE: assert property (dev_oe |-> !cs_n)
    else $error("device drives outside a cycle");
  AST_CTRL_WRITE: assert property (!cs_n && host_oe && addr == hmp_pkg::ADDR_CONTROL |->
    host_data == hmp_pkg::CTRL_WRITE_VAL) else $error("bad control write value");
  AST_BUSY_AFTER_WORD: assert property ($rose(busy) |-> !cs_n && addr == hmp_pkg::ADDR_MAILBOX)
    else $error("busy rose outside a mailbox write");
  AST_IRQ_AFTER_READ: assert property ($rose(irq_n) |-> !cs_n && addr == hmp_pkg::ADDR_MAILBOX && rd_rw)
    else $error("request cleared outside a mailbox read");
endmodule // hmp_bus_asserts

// >>> test/testbench.sv
/* Bench: both ends joined over the bus, host driven over AXI4-Lite,
   queue model of audio bytes. Assumes a 10 MHz aclk. */
`timescale 1ns/1ps
module testbench;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, in_word, out_word = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_bresp, last_rresp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, proc_take = 1'h0, out_load = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        bus_style, input_busy_flag, output_ready_flag, audio_one_valid, audio_two_valid;
  logic [7:0]  audio_one_data, audio_two_data, q1[$], q2[$];
  int          failures = 0, n_checks = 0, seed = 32'h31DC7B61;
  hmp_bus_if bus ();
  hmp_host hmp_host_i (.*);
  hmp_device hmp_device_i (.*);
  hmp_bus_asserts hmp_bus_asserts_i (.aclk(aclk), .aresetn(aresetn), .cs_n(bus.cs_n), .wr_ds_n(bus.wr_ds_n),
    .rd_rw(bus.rd_rw), .addr(bus.addr), .host_data(bus.host_data), .host_oe(bus.host_oe),
    .dev_oe(bus.dev_oe), .busy(bus.busy), .irq_n(bus.irq_n));
  initial forever #50 aclk = ~aclk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // An edge passes first so no strobe is assigned twice in one step
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    last_bresp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [4:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    last_rresp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic cmd(input logic [1:0] op, input logic [1:0] ra, input logic [31:0] wd);
    logic [31:0] st;
    axw(hmp_pkg::OFF_WDATA, wd);
    axw(hmp_pkg::OFF_COMMAND, {28'h0, ra, op});
    check("bresp", last_bresp, hmp_pkg::RESP_OKAY);
    // A second command while a word is in flight must be turned away
    if (op == hmp_pkg::OP_READ_WORD) begin
      axw(hmp_pkg::OFF_COMMAND, 32'h0);
      check("busy bresp", last_bresp, hmp_pkg::RESP_SLVERR);
    end
    repeat (60) begin
      axr(hmp_pkg::OFF_STATUS, st);
      if (st[0] === 1'h0) break;
    end
    check("engine idle", st[0], 1'h0);
  endtask
  task automatic stat(input logic [4:0] e);
    logic [31:0] st;
    axr(hmp_pkg::OFF_STATUS, st);
    check("status", st[4:0], e);
    check("rresp", last_rresp, hmp_pkg::RESP_OKAY);
  endtask
  task automatic pulse(input bit load);
    @(posedge aclk);
    if (load) out_load <= 1'h1;
    else proc_take <= 1'h1;
    @(posedge aclk);
    if (load) out_load <= 1'h0;
    else proc_take <= 1'h0;
    // Host sees the flag pins two flops late
    repeat (2) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    if (audio_one_valid === 1'h1) check("audio one", audio_one_data, q1.size() ? q1.pop_front() : 8'hXX);
    if (audio_two_valid === 1'h1) check("audio two", audio_two_data, q2.size() ? q2.pop_front() : 8'hXX);
  end
  initial begin
    #2000000;
    failures++;
    summarize();
  end
  initial begin
    logic [31:0] w, r;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    stat(5'h00);
    check("irq pin", bus.irq_n, 1'h1);
    axr(5'h14, r);
    check("unmapped", r, 32'h0);
    check("unmapped rresp", last_rresp, hmp_pkg::RESP_SLVERR);
    for (int s = 0; s < 2; s++) begin
      axw(hmp_pkg::OFF_CONFIG, 32'(s));
      w = $random(seed);
      cmd(hmp_pkg::OP_WRITE_WORD, hmp_pkg::ADDR_MAILBOX, w);
      check("word in", in_word, w);
      check("busy", input_busy_flag, 1'h1);
      stat({s[0], 4'h4});
      cmd(hmp_pkg::OP_WRITE_WORD, hmp_pkg::ADDR_MAILBOX, ~w);
      stat({s[0], 4'h6});
      check("word kept", in_word, w);
      cmd(hmp_pkg::OP_WRITE_BYTE, hmp_pkg::ADDR_CONTROL, 32'hFF);
      stat({s[0], 4'h4});
      pulse(1'b0);
      out_word <= ~w;
      pulse(1'b1);
      stat({s[0], 4'h8});
      check("ready", output_ready_flag, 1'h1);
      check("irq pin", bus.irq_n, 1'h0);
      cmd(hmp_pkg::OP_READ_BYTE, hmp_pkg::ADDR_CONTROL, 32'h0);
      axr(hmp_pkg::OFF_RDATA, r);
      check("control", r[7:0], 8'h1A);
      cmd(hmp_pkg::OP_READ_WORD, hmp_pkg::ADDR_MAILBOX, 32'h0);
      axr(hmp_pkg::OFF_RDATA, r);
      check("word out", r, ~w);
      check("ready", output_ready_flag, 1'h0);
      check("irq pin", bus.irq_n, 1'h1);
      for (int k = 0; k < 2; k++) begin
        r = $random(seed);
        if (k == 1) q2.push_back(r[7:0]);
        else q1.push_back(r[7:0]);
        cmd(hmp_pkg::OP_WRITE_BYTE, 2'(2 + k), r);
      end
      cmd(hmp_pkg::OP_READ_BYTE, hmp_pkg::ADDR_AUDIO_ONE, 32'h0);
      stat({s[0], 4'h2});
      cmd(hmp_pkg::OP_WRITE_BYTE, hmp_pkg::ADDR_MAILBOX, w);
      stat({s[0], 4'h2});
    end
    check("audio left", 32'(q1.size() + q2.size()), 32'h0);
    summarize();
  end
endmodule // testbench
